//--- bench/iv_core_asserts.sv
// Port-level checks of the interrupt vectoring unit
`timescale 1ns/1ps
module iv_core_asserts
   import iv_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire iv_cpu_in_t  cpu_in,
   input wire iv_cpu_out_t cpu_out,
   input wire iv_stack_t   stack
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // --------------------------------
   // Entry and return steps
   // --------------------------------
   sequence push_pair;
      stack.we ##1 (stack.we && stack.addr == $past(stack.addr) - 16'h0001);
   endsequence
   sequence hold_then_load;
      cpu_out.stall [*4] ##1 (cpu_out.pc_load && !cpu_out.stall);
   endsequence

   entry_time_a: assert property (cpu_out.irq_take && !$past(cpu_in.sleeping) |-> hold_then_load)
      else $error("vector not loaded four cycles after acceptance");
   push_two_a: assert property (cpu_out.irq_take && !$past(cpu_in.sleeping) |=> push_pair)
      else $error("return address not pushed as two falling bytes");
   gie_clear_a: assert property (cpu_out.irq_take |-> !cpu_out.gie)
      else $error("global enable still set after acceptance");
   take_gated_a: assert property (cpu_out.irq_take |-> $past(cpu_out.gie))
      else $error("acceptance while global enable was off");
   done_only_a: assert property (cpu_out.irq_take |-> $past(cpu_in.instr_done || cpu_in.sleeping))
      else $error("acceptance inside an instruction");
   cli_block_a: assert property (cpu_in.instr_done && cpu_in.op_cli |=> !cpu_out.irq_take)
      else $error("acceptance despite disable in same cycle");
   sei_next_a: assert property (cpu_in.instr_done && cpu_in.op_sei && !cpu_out.gie |=> !cpu_out.irq_take)
      else $error("acceptance before the instruction after enable");
   return_from_interrupt_op_gie_a: assert property (cpu_in.instr_done && cpu_in.op_return_from_interrupt_op && !cpu_out.stall
      && !$past(cpu_out.pc_load) && !$past(cpu_out.pc_load, 2)
      |=> hold_then_load ##0 cpu_out.gie)
      else $error("return not four cycles or enable not restored");
   vec_addr_a: assert property (cpu_out.irq_take && !$past(cpu_in.sleeping) |-> ##4
      (cpu_out.pc_value[4:0] == {cpu_out.vector_num, 1'b0}))
      else $error("vector address does not match vector number");
   one_after_a: assert property (cpu_out.pc_load |=> !cpu_out.irq_take [*2])
      else $error("acceptance right after a program counter load");
   wake_time_a: assert property (cpu_out.irq_take && $past(cpu_in.sleeping) |->
      cpu_out.stall [*8] ##1 (cpu_out.pc_load && !cpu_out.stall))
      else $error("wake entry not eight cycles");
endmodule

bind iv_core iv_core_asserts iv_core_asserts_i (.pclk(pclk), .presetn(presetn), .cpu_in(cpu_in),
   .cpu_out(cpu_out), .stack(stack));

//--- bench/iv_cpu_model.sv
// Behavioural core pipeline and stack memory facing the vectoring unit
`timescale 1ns/1ps
module iv_cpu_model
   import iv_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [1:0]  op,
   input  wire logic        sleep,
   input  wire iv_cpu_out_t cpu_out,
   input  wire iv_stack_t   stack,
   output iv_cpu_in_t       cpu_in,
   output logic [7:0]       stack_rdata
);
   logic [15:0] pc;
   logic [7:0]  mem [65536];

   // ops come from software only, flags never saved by the core
   always_comb begin
      cpu_in            = '0;
      cpu_in.instr_done = presetn && !sleep && !cpu_out.stall && !cpu_out.pc_load;
      cpu_in.sleeping   = sleep;
      cpu_in.op_sei     = cpu_in.instr_done && op == 2'h1;
      cpu_in.op_cli     = cpu_in.instr_done && op == 2'h2;
      cpu_in.op_return_from_interrupt_op    = cpu_in.instr_done && op == 2'h3;
      cpu_in.cur_pc     = pc;
      cpu_in.next_pc    = pc + 16'h0001;
   end

   // Read data toggles when unused so a stale byte never passes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc          <= 16'h0100;
         stack_rdata <= 8'hA5;
      end else begin
         if (cpu_out.pc_load) begin
            pc <= cpu_out.pc_value;
         end else if (cpu_in.instr_done) begin
            pc <= pc + 16'h0001;
         end
         if (stack.we) begin
            mem[stack.addr] <= stack.wdata;
         end
         stack_rdata <= stack.re ? mem[stack.addr] : ~stack_rdata;
      end
   end
endmodule

//--- bench/test_cpu_interrupt_vectoring.sv
// Self-checking bench of the interrupt vectoring unit
`timescale 1ns/1ps
module test_cpu_interrupt_vectoring;
   import iv_pkg::*;
   localparam logic [15:0] BOOT = 16'h1000;
   logic               pclk = 1'h0;
   logic               presetn = 1'h0;
   logic               psel = 1'h0;
   logic               penable = 1'h0;
   logic               pwrite = 1'h0;
   logic [7:0]         paddr = 8'h00;
   logic [31:0]        pwdata = 32'h0;
   logic [31:0]        prdata;
   logic [31:0]        rdq;
   logic               pready;
   logic               pslverr;
   logic [IV_NSRC-1:0] src_event = 8'h00;
   logic [IV_NSRC-1:0] src_level = 8'h00;
   logic [1:0]         op = 2'h0;
   logic               sleep = 1'h0;
   iv_cpu_in_t         cpu_in;
   iv_cpu_out_t        cpu_out;
   iv_stack_t          stack;
   logic [7:0]         stack_rdata;
   logic [15:0]        prev_npc;
   logic [15:0]        ret_q [$];
   int                 n_fail, cmp_count, n_take, cyc, a, b, t;

   always #2.5 pclk = ~pclk;

   iv_core #(.BOOT_START(BOOT)) iv_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .cpu_in(cpu_in), .cpu_out(cpu_out), .stack(stack), .stack_rdata(stack_rdata), .src_event(src_event),
      .src_level(src_level), .boot_reset_fuse(1'h0), .app_section_lock_setting(1'h0),
      .boot_section_lock_setting(1'h0));
   iv_cpu_model iv_cpu_model_i (.pclk(pclk), .presetn(presetn), .op(op), .cpu_out(cpu_out),
      .stack(stack), .cpu_in(cpu_in), .stack_rdata(stack_rdata), .sleep(sleep));

   // Return addresses modelled as a stack of pushes
   always @(posedge pclk) begin
      cyc++;
      if (cpu_out.irq_take === 1'h1) begin
         ret_q.push_front(prev_npc);
         n_take++;
      end
      prev_npc = cpu_in.next_pc;
      if (cyc == 20000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rdq = w ? {31'h0, pslverr} : prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   task automatic wait_load(output logic [15:0] v, output logic [3:0] vn);
      do @(posedge pclk); while (cpu_out.pc_load !== 1'h1);
      v = cpu_out.pc_value;
      vn = cpu_out.vector_num;
   endtask

   task automatic do_op(input logic [1:0] o);
      op <= o;
      do @(posedge pclk); while (cpu_in.instr_done !== 1'h1);
      op <= 2'h0;
   endtask

   task give_verdict;
      if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      logic [15:0] v;
      logic [3:0]  vn;
      void'($urandom(91));
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      repeat (3) @(posedge pclk);
      apb(1'h0, IV_REG_FLAGS, 32'h0);
      chk("flags reset", rdq, 32'h0);
      apb(1'h0, IV_REG_SP, 32'h0);
      chk("sp reset", rdq, 32'h04FF);
      apb(1'h1, 8'h1C, 32'h1);
      chk("unmapped error", rdq, 32'h1);
      chk("reset vector", 32'(cpu_out.reset_vector), 32'h0);
      for (int p = 0; p < 2; p++) begin
         apb(1'h1, IV_REG_FLAGS, 32'h0);
         a = p ? $urandom_range(6, 1) : 0;
         b = $urandom_range(7, a + 1);
         apb(1'h1, IV_REG_CTRL, 32'(p));
         apb(1'h1, IV_REG_ENABLE, 32'hFF);
         src_event <= 8'(1 << a) | 8'(1 << b);
         @(posedge pclk);
         src_event <= 8'h00;
         apb(1'h0, IV_REG_PENDING, 32'h0);
         chk("latched flags", rdq, (1 << a) | (1 << b));
         apb(1'h1, IV_REG_FLAGS, 32'h80);
         wait_load(v, vn);
         t = p ? BOOT : 0;
         chk("vector address", 32'(v), t + 2 * (a + 1));
         chk("vector number", 32'(vn), a + 1);
         chk("pushed pc", {iv_cpu_model_i.mem[16'h04FE], iv_cpu_model_i.mem[16'h04FF]}, ret_q[0]);
         apb(1'h0, IV_REG_PENDING, 32'h0);
         chk("serviced flag", rdq, 1 << b);
         apb(1'h0, IV_REG_FLAGS, 32'h0);
         chk("gie after entry", rdq[7], 32'h0);
         apb(1'h0, IV_REG_SP, 32'h0);
         chk("sp after push", rdq, 32'h04FD);
         apb(1'h1, IV_REG_FLAGS, 32'h80);
         wait_load(v, vn);
         chk("nested vector", 32'(v), t + 2 * (b + 1));
         repeat (2) begin
            repeat (2) @(posedge pclk);
            do_op(2'h3);
            wait_load(v, vn);
            chk("return pc", 32'(v), 32'(ret_q.pop_front()));
            chk("gie on return", 32'(cpu_out.gie), 32'h1);
         end
         apb(1'h0, IV_REG_SP, 32'h0);
         chk("sp after pop", rdq, 32'h04FF);
      end
      apb(1'h1, IV_REG_CTRL, 32'h0);
      apb(1'h1, IV_REG_FLAGS, 32'h0);
      src_event <= 8'h08;
      @(posedge pclk);
      src_event <= 8'h00;
      t = n_take;
      op <= 2'h1;
      @(posedge pclk);
      op <= 2'h2;
      @(posedge pclk);
      op <= 2'h0;
      repeat (8) @(posedge pclk);
      chk("take after enable then disable", n_take, t);
      do_op(2'h1);
      wait_load(v, vn);
      chk("served after enable", 32'(v), 32'h8);
      repeat (2) @(posedge pclk);
      do_op(2'h3);
      wait_load(v, vn);
      chk("return pc again", 32'(v), 32'(ret_q.pop_front()));
      apb(1'h1, IV_REG_FLAGS, 32'h0);
      src_event <= 8'h04;
      @(posedge pclk);
      src_event <= 8'h00;
      apb(1'h1, IV_REG_PENDING, 32'h0);
      apb(1'h0, IV_REG_PENDING, 32'h0);
      chk("flag kept on zero write", rdq, 32'h4);
      apb(1'h1, IV_REG_PENDING, 32'h4);
      apb(1'h0, IV_REG_PENDING, 32'h0);
      chk("flag cleared on one write", rdq, 32'h0);
      apb(1'h1, IV_REG_LEVEL, 32'h20);
      src_level <= 8'h20;
      apb(1'h0, IV_REG_PENDING, 32'h0);
      chk("level present", rdq, 32'h20);
      src_level <= 8'h00;
      apb(1'h0, IV_REG_PENDING, 32'h0);
      chk("level gone", rdq, 32'h0);
      sleep <= 1'h1;
      src_event <= 8'h02;
      @(posedge pclk);
      src_event <= 8'h00;
      apb(1'h1, IV_REG_FLAGS, 32'h80);
      wait_load(v, vn);
      sleep <= 1'h0;
      chk("wake vector", 32'(v), 32'h4);
      give_verdict();
   end
endmodule

//--- logic/iv_core.sv
// Interrupt vectoring unit: arbitration, entry, return and APB registers
//
// How it works
// - Own vectors at bottom; lower address wins
// - Reset first, comparator zero next
// - Take only with source and global enable
// - Table select moves vectors to boot
// - Boot reset fuse moves reset vector
// - Lock settings suppress by PC section
// - Accepting clears global enable
// - Enable inside handler allows nesting
// - Return sets global enable
// - Flag cleared when PC vectored
// - Write one clears flag
// - Latched flags served later by priority
// - Level sources request only while present
// - One instruction after return first
// - Disable acts in its own cycle
// - Instruction after enable runs first
// - Entry four cycles, pushes PC
// - Vector jump given three cycles
// - Only at instruction completion or while sleeping
// - Wake adds four cycles
// - Return four cycles, pop, SP plus two
// - Global enable is flags bit 7
// - Push lowers SP by two
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module iv_core
   import iv_pkg::*;
#(
   parameter logic [15:0]          BOOT_START = IV_BOOT_START
)
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic      [31:0]        prdata,
   output logic                    pslverr,
   input  wire iv_cpu_in_t         cpu_in,
   output iv_cpu_out_t             cpu_out,
   output iv_stack_t               stack,
   input  wire logic [7:0]         stack_rdata,
   input  wire logic [IV_NSRC-1:0] src_event,
   input  wire logic [IV_NSRC-1:0] src_level,
   input  wire logic               boot_reset_fuse,
   input  wire logic               app_section_lock_setting,
   input  wire logic               boot_section_lock_setting
);

   typedef struct packed {
      logic               pready;
      logic [31:0]        prdata;
      logic               pslverr;
      logic [7:0]         cpu_flags_register;
      logic               vector_table_select;
      logic [IV_NSRC-1:0] enable;
      logic [IV_NSRC-1:0] level_type;
      logic [15:0]        sp;
      iv_state_t          st;
      logic [2:0]         cnt;
      logic               wake;
      logic [IV_IDXW-1:0] win;
      logic [15:0]        ret_pc;
      logic               guard;
      logic [2:0]         fuse_sync;
      logic [2:0]         app_sync;
      logic [2:0]         boot_sync;
      logic [1:0]         strap_cnt;
      iv_cpu_out_t        co;
      iv_stack_t          stk;
   } iv_core_state_t;

   iv_core_state_t     r;
   iv_core_state_t     next_r;

   logic [IV_NSRC-1:0] req;
   logic [IV_NSRC-1:0] flags;
   logic [IV_NSRC-1:0] sw_clr;
   logic [IV_NSRC-1:0] hw_clr;
   logic [IV_NSRC-1:0] live_req;
   logic               arb_valid;
   logic [IV_IDXW-1:0] arb_idx;

   // ----------------------------------------------------------------
   // Request sources and arbitration
   // ----------------------------------------------------------------
   iv_flag_bank u_flags (
      .pclk       (pclk),
      .presetn    (presetn),
      .src_event  (src_event),
      .src_level  (src_level),
      .level_type (r.level_type),
      .sw_clr     (sw_clr),
      .hw_clr     (hw_clr),
      .req        (req),
      .flags      (flags)
   );

   assign live_req = req & r.enable;

   iv_prio_arb u_arb (
      .req   (live_req),
      .valid (arb_valid),
      .idx   (arb_idx)
   );

   // ----------------------------------------------------------------
   // Combinational helpers
   // ----------------------------------------------------------------
   logic               gie;
   logic               in_boot;
   logic               suppress;
   logic               can_take;
   logic               apb_hit;
   logic               apb_done;
   logic               apb_wr;
   logic [31:0]        rd_mux;
   logic [15:0]        vec_base;
   logic [IV_VECW-1:0] win_num;
   logic [15:0]        win_addr;

   // Global enable lives in bit 7
   assign gie      = r.cpu_flags_register[IV_GIE_BIT];
   assign in_boot  = cpu_in.cur_pc >= BOOT_START;

   assign suppress = (r.app_sync[2] & ~in_boot & r.vector_table_select)
                   | (r.boot_sync[2] & in_boot & ~r.vector_table_select);

   assign vec_base = r.vector_table_select ? BOOT_START : IV_APP_START;

   // Vector 0 is reset, source 0 is comparator zero
   assign win_num  = {1'b0, r.win} + IV_VECW'(1);

   // Vector address rises with vector number
   assign win_addr = vec_base + 16'(win_num) * IV_VEC_WORDS;

   // Global enable gate; disable wins in its own cycle
   assign can_take = gie & ~cpu_in.op_cli & ~suppress & arb_valid & ~r.guard;

   assign apb_done = psel & penable & r.pready;
   assign apb_wr   = apb_done & pwrite & ~r.pslverr;

   always_comb begin
      apb_hit = 1'b1;
      rd_mux  = '0;
      unique case (paddr)
         IV_REG_FLAGS:   rd_mux[7:0]         = r.cpu_flags_register;
         IV_REG_CTRL:    rd_mux[0]           = r.vector_table_select;
         IV_REG_ENABLE:  rd_mux[IV_NSRC-1:0] = r.enable;
         IV_REG_PENDING: rd_mux[IV_NSRC-1:0] = req;
         IV_REG_LEVEL:   rd_mux[IV_NSRC-1:0] = r.level_type;
         IV_REG_SP:      rd_mux[15:0]        = r.sp;
         IV_REG_STATUS:  rd_mux              = {r.co.reset_vector, 5'h00, r.guard, 1'b0, r.win,
                                                1'b0, suppress, r.wake, r.st};
         default:        apb_hit             = 1'b0;
      endcase
   end

   // Only ones written to pending clear flags
   assign sw_clr = (apb_wr && paddr == IV_REG_PENDING) ? pwdata[IV_NSRC-1:0] : '0;

   // Clear serviced flag as PC is vectored
   always_comb begin
      hw_clr = '0;
      if (r.st == IV_ENTRY && r.cnt == IV_ENTRY_CYC - 3'h1) begin
         hw_clr[r.win] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_r             = r;
      next_r.co.irq_take = 1'b0;
      next_r.co.pc_load  = 1'b0;
      next_r.stk.we      = 1'b0;
      next_r.stk.re      = 1'b0;

      // Strap pins: two-flop sync, third stage for later use
      next_r.fuse_sync = {r.fuse_sync[1:0], boot_reset_fuse};
      next_r.app_sync  = {r.app_sync[1:0], app_section_lock_setting};
      next_r.boot_sync = {r.boot_sync[1:0], boot_section_lock_setting};
      if (r.strap_cnt != IV_STRAP_CYC) begin
         next_r.strap_cnt = r.strap_cnt + 2'h1;
      end
      // Reset vector latched once after release
      if (r.strap_cnt == IV_STRAP_CYC - 2'h1) begin
         next_r.co.reset_vector = r.fuse_sync[1] ? BOOT_START : IV_APP_START;
      end

      // APB: one wait state, answer registered
      next_r.pready = 1'b0;
      if (psel && penable && !r.pready) begin
         next_r.pready  = 1'b1;
         next_r.prdata  = pwrite ? 32'h0000_0000 : rd_mux;
         next_r.pslverr = ~apb_hit;
      end
      if (apb_done) begin
         next_r.pslverr = 1'b0;
      end
      if (apb_wr) begin
         unique case (paddr)
            IV_REG_FLAGS:  next_r.cpu_flags_register  = pwdata[7:0];
            IV_REG_CTRL:   next_r.vector_table_select = pwdata[0];
            IV_REG_ENABLE: next_r.enable              = pwdata[IV_NSRC-1:0];
            IV_REG_LEVEL:  next_r.level_type          = pwdata[IV_NSRC-1:0];
            IV_REG_SP:     next_r.sp                  = pwdata[15:0];
            default:       next_r.sp                  = next_r.sp;
         endcase
      end

      // Core enable and disable instructions
      if (cpu_in.instr_done && cpu_in.op_sei) begin
         // Re-enable inside a handler lets others nest
         next_r.cpu_flags_register[IV_GIE_BIT] = 1'b1;
      end
      if (cpu_in.instr_done && cpu_in.op_cli) begin
         next_r.cpu_flags_register[IV_GIE_BIT] = 1'b0;
      end

      unique case (r.st)
         IV_IDLE: begin
            next_r.co.stall = 1'b0;
            if (cpu_in.instr_done && cpu_in.op_return_from_interrupt_op) begin
               next_r.st       = IV_RETURN;
               next_r.cnt      = '0;
               next_r.co.stall = 1'b1;
            end else if (cpu_in.instr_done && r.guard) begin
               next_r.guard = 1'b0;
            end else if (can_take && (cpu_in.instr_done || cpu_in.sleeping)) begin
               // Decided only at a completed instruction or while sleeping
               // Enable set this cycle is not yet visible
               // Latched flags served once both enables are on
               next_r.st          = cpu_in.sleeping ? IV_WAKE : IV_ENTRY;
               next_r.wake        = cpu_in.sleeping;
               next_r.cnt         = '0;
               next_r.win         = arb_idx;
               // Return to the first unexecuted instruction
               next_r.ret_pc      = cpu_in.next_pc;
               next_r.co.irq_take = 1'b1;
               next_r.co.stall    = 1'b1;
               next_r.cpu_flags_register[IV_GIE_BIT] = 1'b0;
            end
         end

         IV_WAKE: begin
            // Extra cycles on wake from sleep
            next_r.cnt = r.cnt + 3'h1;
            if (r.cnt == IV_WAKE_CYC - 3'h1) begin
               next_r.st  = IV_ENTRY;
               next_r.cnt = '0;
            end
         end

         IV_ENTRY: begin
            // Push PC during the entry cycles
            next_r.cnt = r.cnt + 3'h1;
            if (r.cnt == 3'h0) begin
               next_r.stk.we    = 1'b1;
               next_r.stk.addr  = r.sp;
               next_r.stk.wdata = r.ret_pc[7:0];
            end
            if (r.cnt == 3'h1) begin
               next_r.stk.we    = 1'b1;
               next_r.stk.addr  = r.sp - IV_SP_STEP;
               next_r.stk.wdata = r.ret_pc[15:8];
               next_r.sp        = next_r.sp - IV_PC_BYTES;
            end
            if (r.cnt == IV_ENTRY_CYC - 3'h1) begin
               next_r.co.pc_load    = 1'b1;
               next_r.co.pc_value   = win_addr;
               next_r.co.vector_num = win_num;
               next_r.co.stall      = 1'b0;
               next_r.st            = IV_JUMP;
               next_r.cnt           = '0;
               next_r.wake          = 1'b0;
            end
         end

         IV_JUMP: begin
            // Jump at the vector runs undisturbed
            next_r.cnt = r.cnt + 3'h1;
            if (r.cnt == IV_JMP_CYC - 3'h1) begin
               next_r.st  = IV_IDLE;
               next_r.cnt = '0;
            end
         end

         IV_RETURN: begin
            // Pop high then low byte over four cycles
            next_r.cnt = r.cnt + 3'h1;
            if (r.cnt == 3'h0) begin
               next_r.stk.re   = 1'b1;
               next_r.stk.addr = r.sp + IV_SP_STEP;
            end
            if (r.cnt == 3'h1) begin
               next_r.stk.re   = 1'b1;
               next_r.stk.addr = r.sp + IV_PC_BYTES;
            end
            // Read data trails its strobe by one cycle
            if (r.cnt == 3'h2) begin
               next_r.ret_pc[15:8] = stack_rdata;
            end
            if (r.cnt == IV_RETURN_FROM_INTERRUPT_OP_CYC - 3'h1) begin
               next_r.ret_pc[7:0] = stack_rdata;
               next_r.co.pc_load  = 1'b1;
               next_r.co.pc_value = {r.ret_pc[15:8], stack_rdata};
               next_r.co.stall    = 1'b0;
               next_r.sp          = next_r.sp + IV_PC_BYTES;
               next_r.cpu_flags_register[IV_GIE_BIT] = 1'b1;
               // Hold off until one instruction completes
               next_r.guard = 1'b1;
               next_r.st    = IV_IDLE;
               next_r.cnt   = '0;
            end
         end
      endcase

      // Lower flag bits are never saved here; handlers do that
      next_r.co.gie = next_r.cpu_flags_register[IV_GIE_BIT];
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r                    <= '0;
         r.cpu_flags_register <= IV_FLAGS_RST;
         r.sp                 <= IV_SP_RST;
         r.st                 <= IV_IDLE;
         r.co.reset_vector    <= IV_APP_START;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign pready  = r.pready;
   assign prdata  = r.prdata;
   assign pslverr = r.pslverr;
   assign cpu_out = r.co;
   assign stack   = r.stk;

endmodule

//--- logic/iv_flag_bank.sv
// Per-source pending flags and level/flag request selection
`timescale 1ns/1ps
module iv_flag_bank
   import iv_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic [IV_NSRC-1:0] src_event,
   input  wire logic [IV_NSRC-1:0] src_level,
   input  wire logic [IV_NSRC-1:0] level_type,
   input  wire logic [IV_NSRC-1:0] sw_clr,
   input  wire logic [IV_NSRC-1:0] hw_clr,
   output logic      [IV_NSRC-1:0] req,
   output logic      [IV_NSRC-1:0] flags
);

   iv_flag_state_t r;
   iv_flag_state_t next_r;

   // ----------------------------------------------------------------
   // Flags latch until serviced or cleared; a new event beats a clear
   // ----------------------------------------------------------------
   always_comb begin
      next_r      = r;
      next_r.flag = (r.flag & ~(sw_clr | hw_clr)) | src_event;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign flags = r.flag;

   for (genvar i = 0; i < IV_NSRC; i++) begin : g_req
      assign req[i] = level_type[i] ? src_level[i] : r.flag[i];
   end

endmodule

//--- logic/iv_pkg.sv
// Shared constants, register map and carrier types for the interrupt vectoring unit
package iv_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int          IV_NSRC        = 8;
   localparam int          IV_IDXW        = 3;
   localparam int          IV_VECW        = 4;
   localparam int          IV_GIE_BIT     = 7;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0]  IV_REG_FLAGS   = 8'h00;
   localparam logic [7:0]  IV_REG_CTRL    = 8'h04;
   localparam logic [7:0]  IV_REG_ENABLE  = 8'h08;
   localparam logic [7:0]  IV_REG_PENDING = 8'h0C;
   localparam logic [7:0]  IV_REG_LEVEL   = 8'h10;
   localparam logic [7:0]  IV_REG_SP      = 8'h14;
   localparam logic [7:0]  IV_REG_STATUS  = 8'h18;

   // ----------------------------------------------------------------
   // Reset values and addresses
   // ----------------------------------------------------------------
   localparam logic [7:0]  IV_FLAGS_RST   = 8'h00;
   localparam logic [15:0] IV_SP_RST      = 16'h04FF;
   localparam logic [15:0] IV_BOOT_START  = 16'h1000;
   localparam logic [15:0] IV_APP_START   = 16'h0000;
   localparam logic [15:0] IV_VEC_WORDS   = 16'h0002;
   localparam logic [15:0] IV_SP_STEP     = 16'h0001;
   localparam logic [15:0] IV_PC_BYTES    = 16'h0002;

   // ----------------------------------------------------------------
   // Sequence lengths in clock cycles
   // ----------------------------------------------------------------
   localparam logic [2:0]  IV_ENTRY_CYC   = 3'h4;
   localparam logic [2:0]  IV_WAKE_CYC    = 3'h4;
   localparam logic [2:0]  IV_JMP_CYC     = 3'h3;
   localparam logic [2:0]  IV_RETURN_FROM_INTERRUPT_OP_CYC    = 3'h4;
   localparam logic [1:0]  IV_STRAP_CYC   = 2'h3;

   typedef enum logic [2:0] {IV_IDLE, IV_WAKE, IV_ENTRY, IV_JUMP, IV_RETURN} iv_state_t;

   typedef struct packed {
      logic        instr_done;
      logic        op_sei;
      logic        op_cli;
      logic        op_return_from_interrupt_op;
      logic        sleeping;
      logic [15:0] next_pc;
      logic [15:0] cur_pc;
   } iv_cpu_in_t;

   typedef struct packed {
      logic              irq_take;
      logic              stall;
      logic              pc_load;
      logic [15:0]       pc_value;
      logic [IV_VECW-1:0] vector_num;
      logic              gie;
      logic [15:0]       reset_vector;
   } iv_cpu_out_t;

   typedef struct packed {
      logic        we;
      logic        re;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } iv_stack_t;

   typedef struct packed {
      logic [IV_NSRC-1:0] flag;
   } iv_flag_state_t;

endpackage

//--- logic/iv_prio_arb.sv
// Fixed-priority arbiter: lowest index wins
`timescale 1ns/1ps
module iv_prio_arb
   import iv_pkg::*;
(
   input  wire logic [IV_NSRC-1:0] req,
   output logic                    valid,
   output logic [IV_IDXW-1:0]      idx
);

   // ----------------------------------------------------------------
   // Scan from the top so index 0 is written last and ends up on top
   // ----------------------------------------------------------------
   always_comb begin
      valid = 1'b0;
      idx   = '0;
      for (int i = IV_NSRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            valid = 1'b1;
            idx   = IV_IDXW'(i);
         end
      end
   end

endmodule
